// ### core/dch_pkg.sv
// shared constants and carrier types for the debug command handler
package dch_pkg;

  // opcodes received from the debug host
  localparam logic [7:0] OP_WR_CTL = 8'h04;
  localparam logic [7:0] OP_RD_CTL = 8'h05;
  localparam logic [7:0] OP_WR_PC = 8'h06;
  localparam logic [7:0] OP_RD_PC = 8'h07;
  localparam logic [7:0] OP_WR_REG = 8'h08;
  localparam logic [7:0] OP_RD_REG = 8'h09;

  // debugger control register layout and reset value
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam int CTL_DBG_MODE_POS = 7;

  // value returned for a blocked instruction pointer read
  localparam logic [15:0] PC_BLOCKED = 16'hffff;

  // register file geometry
  localparam int RF_ADDR_W = 12;
  localparam int BURST_CNT_W = 9;
  localparam logic [8:0] BURST_MAX = 9'h100;

  // flash control register window still writable under read protection
  localparam logic [11:0] FLASH_CTL_LO = 12'hff8;
  localparam logic [11:0] FLASH_CTL_HI = 12'hfff;

  // one byte travelling with its valid flag
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } dch_byte_t;

  // register file request
  typedef struct packed {
    logic we;
    logic re;
    logic [11:0] addr;
    logic [7:0] wdata;
  } dch_rf_req_t;

  // instruction pointer load request
  typedef struct packed {
    logic load;
    logic [15:0] value;
  } dch_pc_req_t;

endpackage

// ### core/dch_cmd_handler.sv
// debug command handler: opcode and payload decoding for the debug link
`timescale 1ns/1ps

module dch_cmd_handler (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // bytes from the debug serial pin deserialiser
  input wire dch_pkg::dch_byte_t rx_byte,
  output logic rx_ready,
  // bytes to the debug serial pin serialiser
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // read-protect option and debug state
  input wire logic read_protect,
  output logic halt_for_debug_bit,
  output logic [7:0] debugger_control_reg,
  // cpu instruction pointer
  input wire logic [15:0] cpu_instruction_pointer,
  output dch_pkg::dch_pc_req_t pc_req,
  // register file port, read data valid the cycle after re
  output dch_pkg::dch_rf_req_t rf_req,
  input wire logic [7:0] rf_rdata
);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CTL_DATA,
    ST_PC_HI,
    ST_PC_LO,
    ST_ADR_HI,
    ST_ADR_LO,
    ST_SIZE,
    ST_WDATA,
    ST_RD_REQ,
    ST_RD_WAIT,
    ST_RD_CAP,
    ST_SEND
  } dch_state_t;

  // size byte to burst length, zero standing for the full 256
  function automatic logic [8:0] burst_len(input logic [7:0] size);
    burst_len = (size == 8'h00) ? dch_pkg::BURST_MAX : {1'b0, size};
  endfunction

  function automatic logic in_flash_ctl(input logic [11:0] a);
    in_flash_ctl = (a >= dch_pkg::FLASH_CTL_LO) &&
                   (a <= dch_pkg::FLASH_CTL_HI);
  endfunction

  dch_state_t state_q, state_d;
  logic [7:0] ctl_q;
  logic [7:0] opcode_q;
  logic [7:0] pc_hi_q;
  logic [11:0] addr_q;
  logic [8:0] cnt_q;
  logic [7:0] tx_data_q;
  logic [7:0] tx_next_q;
  logic tx_more_q;
  logic rf_we_q;
  logic rf_re_q;
  logic [11:0] rf_addr_q;
  logic [7:0] rf_wdata_q;
  logic pc_load_q;
  logic [15:0] pc_value_q;

  wire dbg_mode = ctl_q[dch_pkg::CTL_DBG_MODE_POS];
  wire rx_take = rx_byte.valid && rx_ready;
  wire tx_done = tx_valid && tx_ready;
  wire [7:0] rx_d = rx_byte.data;
  wire last_byte = (cnt_q == 9'h001);
  wire [11:0] addr_inc = addr_q + 12'h001;

  // under protection the debug bit may be raised but never dropped
  wire [7:0] ctl_new = (read_protect && dbg_mode) ?
    (rx_d | (8'h01 << dch_pkg::CTL_DBG_MODE_POS)) : rx_d;

  // pointer access only in debug mode and without protection
  wire pc_allowed = dbg_mode && !read_protect;
  wire [15:0] pc_view = pc_allowed ? cpu_instruction_pointer
                                   : dch_pkg::PC_BLOCKED;

  // write data is kept only when mode and protection permit it
  wire wr_allowed = dbg_mode &&
    (!read_protect || in_flash_ctl(addr_q));

  wire is_rx_state = (state_q == ST_IDLE) || (state_q == ST_CTL_DATA) ||
    (state_q == ST_PC_HI) || (state_q == ST_PC_LO) ||
    (state_q == ST_ADR_HI) || (state_q == ST_ADR_LO) ||
    (state_q == ST_SIZE) || (state_q == ST_WDATA);

  assign rx_ready = is_rx_state;
  assign tx_valid = (state_q == ST_SEND);
  assign tx_data = tx_data_q;
  assign halt_for_debug_bit = dbg_mode;
  assign debugger_control_reg = ctl_q;
  assign rf_req = '{we: rf_we_q, re: rf_re_q, addr: rf_addr_q,
                    wdata: rf_wdata_q};
  assign pc_req = '{load: pc_load_q, value: pc_value_q};

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (rx_take) begin
          case (rx_d)
            dch_pkg::OP_WR_CTL: state_d = ST_CTL_DATA;
            dch_pkg::OP_RD_CTL: state_d = ST_SEND;
            dch_pkg::OP_WR_PC: state_d = ST_PC_HI;
            dch_pkg::OP_RD_PC: state_d = ST_SEND;
            dch_pkg::OP_WR_REG: state_d = ST_ADR_HI;
            dch_pkg::OP_RD_REG: state_d = ST_ADR_HI;
            default: state_d = ST_IDLE;
          endcase
        end
      end
      ST_CTL_DATA: if (rx_take) state_d = ST_IDLE;
      ST_PC_HI: if (rx_take) state_d = ST_PC_LO;
      ST_PC_LO: if (rx_take) state_d = ST_IDLE;
      ST_ADR_HI: if (rx_take) state_d = ST_ADR_LO;
      ST_ADR_LO: if (rx_take) state_d = ST_SIZE;
      ST_SIZE: begin
        if (rx_take) begin
          state_d = (opcode_q == dch_pkg::OP_RD_REG) ? ST_RD_REQ
                                                     : ST_WDATA;
        end
      end
      ST_WDATA: if (rx_take && last_byte) state_d = ST_IDLE;
      ST_RD_REQ: state_d = ST_RD_WAIT;
      ST_RD_WAIT: state_d = ST_RD_CAP;
      ST_RD_CAP: state_d = ST_SEND;
      ST_SEND: begin
        if (tx_done) begin
          if (opcode_q == dch_pkg::OP_RD_REG) begin
            state_d = last_byte ? ST_IDLE : ST_RD_REQ;
          end else begin
            state_d = tx_more_q ? ST_SEND : ST_IDLE;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // debugger control register; only a device reset clears a locked bit
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_q <= dch_pkg::CTL_RESET;
    end else if (state_q == ST_CTL_DATA && rx_take) begin
      ctl_q <= ctl_new;
    end
  end

  // opcode, address and burst count
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      opcode_q <= 8'h00;
      addr_q <= 12'h000;
      cnt_q <= 9'h000;
    end else begin
      if (state_q == ST_IDLE && rx_take) begin
        opcode_q <= rx_d;
      end
      if (state_q == ST_ADR_HI && rx_take) begin
        // upper nibble of this byte is zero by framing
        addr_q <= {rx_d[3:0], addr_q[7:0]};
      end
      if (state_q == ST_ADR_LO && rx_take) begin
        addr_q <= {addr_q[11:8], rx_d};
      end
      if (state_q == ST_SIZE && rx_take) begin
        cnt_q <= burst_len(rx_d);
      end
      if ((state_q == ST_WDATA && rx_take) ||
          (state_q == ST_SEND && tx_done &&
           opcode_q == dch_pkg::OP_RD_REG)) begin
        addr_q <= addr_inc;
        cnt_q <= cnt_q - 9'h001;
      end
    end
  end

  // register file strobes, one cycle each
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rf_we_q <= 1'b0;
      rf_re_q <= 1'b0;
      rf_addr_q <= 12'h000;
      rf_wdata_q <= 8'h00;
    end else begin
      // the whole frame is still consumed when the data is dropped
      rf_we_q <= (state_q == ST_WDATA) && rx_take && wr_allowed;
      rf_re_q <= (state_q == ST_RD_REQ);
      if (state_q == ST_WDATA && rx_take) begin
        rf_addr_q <= addr_q;
        rf_wdata_q <= rx_d;
      end else if (state_q == ST_RD_REQ) begin
        rf_addr_q <= addr_q;
      end
    end
  end

  // instruction pointer load, pulsed after the low byte
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_hi_q <= 8'h00;
      pc_load_q <= 1'b0;
      pc_value_q <= 16'h0000;
    end else begin
      pc_load_q <= (state_q == ST_PC_LO) && rx_take && pc_allowed;
      if (state_q == ST_PC_HI && rx_take) begin
        pc_hi_q <= rx_d;
      end
      if (state_q == ST_PC_LO && rx_take) begin
        pc_value_q <= {pc_hi_q, rx_d};
      end
    end
  end

  // outgoing bytes; pointer is sampled once so both halves match
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_data_q <= 8'h00;
      tx_next_q <= 8'h00;
      tx_more_q <= 1'b0;
    end else begin
      if (state_q == ST_IDLE && rx_take &&
          rx_d == dch_pkg::OP_RD_CTL) begin
        tx_data_q <= ctl_q;
        tx_more_q <= 1'b0;
      end else if (state_q == ST_IDLE && rx_take &&
                   rx_d == dch_pkg::OP_RD_PC) begin
        tx_data_q <= pc_view[15:8];
        tx_next_q <= pc_view[7:0];
        tx_more_q <= 1'b1;
      end else if (state_q == ST_RD_CAP) begin
        tx_data_q <= rf_rdata;
        tx_more_q <= 1'b0;
      end else if (state_q == ST_SEND && tx_done && tx_more_q) begin
        tx_data_q <= tx_next_q;
        tx_more_q <= 1'b0;
      end
    end
  end

endmodule

// ### test/dch_cmd_monitor.sv
// port checker for the debug command handler
`timescale 1ns/1ps
module dch_cmd_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // host byte streams
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  // debug state and requests
  input wire logic read_protect,
  input wire logic halt_for_debug_bit,
  input wire logic [7:0] debugger_control_reg,
  input wire dch_pkg::dch_pc_req_t pc_req,
  input wire dch_pkg::dch_rf_req_t rf_req,
  input wire logic [7:0] rf_rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_bit_mirror: assert property (
    halt_for_debug_bit == debugger_control_reg[7])
    else $error("debug bit differs from control bit");
  a_prot_hold: assert property (
    read_protect && halt_for_debug_bit |=> halt_for_debug_bit)
    else $error("debug bit cleared under protection");
  a_pc_gate: assert property (
    pc_req.load |-> $past(halt_for_debug_bit) && !$past(read_protect))
    else $error("pointer loaded while blocked");
  a_we_gate: assert property (
    rf_req.we |-> $past(halt_for_debug_bit))
    else $error("register write outside debug mode");
  a_we_flash: assert property (
    rf_req.we && $past(read_protect) |->
      rf_req.addr >= dch_pkg::FLASH_CTL_LO)
    else $error("protected write outside flash window");
  a_rd_data: assert property (
    rf_req.re |-> ##2 tx_valid && tx_data == $past(rf_rdata))
    else $error("read byte not offered two cycles on");
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("offered byte dropped or changed");
  a_send_mute: assert property (
    tx_valid |-> !rx_ready)
    else $error("host byte accepted while sending");
endmodule

// ### test/dch_host_model.sv
// debug host model driving both byte streams
`timescale 1ns/1ps
module dch_host_model (
  // clock
  input wire logic ref_clk,
  // host to handler
  output dch_pkg::dch_byte_t rx_byte,
  input wire logic rx_ready,
  // handler to host
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  int lag = 1;
  initial begin
    rx_byte = '{1'b0, 8'h00};
    tx_ready = 1'b0;
  end
  // idle lane shows inverted data so stale bytes never look valid
  task automatic frame(input logic [7:0] q[$]);
    @(posedge ref_clk);
    foreach (q[i]) begin
      rx_byte <= '{1'b1, q[i]};
      do @(posedge ref_clk); while (rx_ready !== 1'b1);
    end
    rx_byte <= '{1'b0, ~rx_byte.data};
  endtask
  // lag of at least one edge keeps ready from being driven twice
  task automatic recv(output logic [7:0] b);
    repeat (lag) @(posedge ref_clk);
    tx_ready <= 1'b1;
    do @(posedge ref_clk); while (tx_valid !== 1'b1);
    b = tx_data;
    tx_ready <= 1'b0;
  endtask
endmodule

// ### test/tb_debug_command_handler.sv
// self-checking bench for the debug command handler
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
  err_count++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_debug_command_handler;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic read_protect = 1'b0;
  logic [15:0] cpu_ip = 16'habcd;
  logic [7:0] rf_rdata = 8'h00;
  dch_pkg::dch_byte_t rx_byte;
  dch_pkg::dch_pc_req_t pc_req;
  dch_pkg::dch_rf_req_t rf_req;
  logic rx_ready, tx_valid, tx_ready, halt_bit;
  logic [7:0] tx_data, ctl, b;
  logic [7:0] rf [4096];
  logic [15:0] pc_seen;
  int err_count = 0, checks_done = 0, loads = 0;
  dch_cmd_handler dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .rx_byte(rx_byte), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .read_protect(read_protect),
    .halt_for_debug_bit(halt_bit), .debugger_control_reg(ctl),
    .cpu_instruction_pointer(cpu_ip), .pc_req(pc_req),
    .rf_req(rf_req), .rf_rdata(rf_rdata));
  dch_host_model host (.ref_clk(ref_clk), .rx_byte(rx_byte),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));
  initial foreach (rf[i]) rf[i] = 8'h5a;
  initial forever #4 ref_clk = ~ref_clk;
  // read data toggles outside its valid cycle
  always @(posedge ref_clk) begin
    rf_rdata <= rf_req.re ? rf[rf_req.addr] : ~rf_rdata;
    if (rf_req.we) rf[rf_req.addr] <= rf_req.wdata;
    if (pc_req.load) begin
      pc_seen <= pc_req.value;
      loads++;
    end
  end
  task automatic rd_ctl(input logic [7:0] e);
    host.frame({dch_pkg::OP_RD_CTL});
    host.recv(b);
    `CHK(b, e)
  endtask
  task automatic rd_pc(input logic [15:0] e);
    logic [7:0] h;
    host.frame({dch_pkg::OP_RD_PC});
    host.recv(h);
    host.recv(b);
    `CHK({h, b}, e)
  endtask
  task automatic t_ctl_pc();
    rd_ctl(dch_pkg::CTL_RESET);
    rd_pc(dch_pkg::PC_BLOCKED);
    host.frame({dch_pkg::OP_WR_PC, 8'h56, 8'h78});
    host.frame({dch_pkg::OP_WR_CTL, 8'h81});
    // an undecoded opcode is swallowed and must not disturb what follows
    host.frame({8'hee});
    rd_ctl(8'h81);
    host.lag = 3;
    rd_pc(cpu_ip);
    host.lag = 1;
    host.frame({dch_pkg::OP_WR_PC, 8'h12, 8'h34});
    repeat (2) @(posedge ref_clk);
    `CHK(loads, 1)
    `CHK(pc_seen, 16'h1234)
  endtask
  task automatic t_wr_rd();
    logic [7:0] q[$];
    host.frame({dch_pkg::OP_WR_REG, 8'h0f, 8'hff, 8'h02, 8'h11, 8'h22});
    q = {dch_pkg::OP_WR_REG, 8'h01, 8'h00, 8'h00};
    for (int i = 0; i < 256; i++) q.push_back(8'(i));
    host.frame(q);
    host.frame({dch_pkg::OP_RD_REG, 8'h01, 8'h00, 8'h00});
    for (int i = 0; i < 256; i++) begin
      host.recv(b);
      `CHK(b, 8'(i))
    end
    `CHK({rf[12'hfff], rf[12'h000]}, 16'h1122)
    `CHK(rf[12'h200], 8'h5a)
    // short read across the top of the address space
    host.frame({dch_pkg::OP_RD_REG, 8'h0f, 8'hff, 8'h02});
    host.recv(b);
    `CHK(b, 8'h11)
    host.recv(b);
    `CHK(b, 8'h22)
    host.frame({dch_pkg::OP_WR_CTL, 8'h00});
    host.frame({dch_pkg::OP_WR_REG, 8'h03, 8'h00, 8'h01, 8'h77});
    // the write strobe lands one edge late, so look one edge after that
    repeat (2) @(posedge ref_clk);
    `CHK(rf[12'h300], 8'h5a)
  endtask
  task automatic t_protect();
    host.frame({dch_pkg::OP_WR_CTL, 8'h80});
    read_protect <= 1'b1;
    host.frame({dch_pkg::OP_WR_REG, 8'h0f, 8'hf7, 8'h02, 8'h33, 8'h44});
    host.frame({dch_pkg::OP_WR_CTL, 8'h05});
    rd_ctl(8'h85);
    `CHK(halt_bit, 1'b1)
    rd_pc(dch_pkg::PC_BLOCKED);
    host.frame({dch_pkg::OP_WR_PC, 8'h00, 8'h01});
    repeat (2) @(posedge ref_clk);
    `CHK(loads, 1)
    `CHK({rf[12'hff7], rf[12'hff8]}, 16'h5a44)
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    read_protect <= 1'b0;
    @(posedge ref_clk);
    `CHK(ctl, dch_pkg::CTL_RESET)
    `CHK(halt_bit, 1'b0)
    // the link must work again straight after a mid-run reset
    rd_ctl(dch_pkg::CTL_RESET);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_ctl_pc();
    t_wr_rd();
    t_protect();
    tally_and_finish();
  end
  // the full run needs under two thousand cycles; this is over twenty times that
  initial begin
    #(40000 * 8);
    err_count++;
    tally_and_finish();
  end
endmodule
bind dch_cmd_handler dch_cmd_monitor u_mon (.ref_clk(ref_clk),
  .arst_n(arst_n), .rx_ready(rx_ready), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready), .read_protect(read_protect),
  .halt_for_debug_bit(halt_for_debug_bit),
  .debugger_control_reg(debugger_control_reg), .pc_req(pc_req),
  .rf_req(rf_req), .rf_rdata(rf_rdata));
